// ### verilog/icss_slave.sv
// i2c slave byte engine with address/data hold, 10-bit handshake, stretch
// assumes scl/sda are open drain; oe high pulls the line low
// Functional notes
// - address hold: after 8th fall of matching address, clear release, flag irq
// - held byte acknowledged with ack_value_sel once release bit is set
// - after acking a read address, hardware clears release bit
// - buffer write in transmit sets buffer full; shifted after release
// - master ack on 9th pulse copied into ack received status
// - master nack: release bus, no scl hold
// - 10-bit high then low byte sets update flag, ack, irq
// - update flag stretches scl without clearing release; address write frees
// - low byte mismatch: irq and update set, buffer full and release unchanged
// - 10-bit hold behaviour same as 7-bit plus update handshake
// - stretch enable clears release and holds scl after each ack that leads into receiving a data byte
// - buffer full never affects stretching; reads always clear release
// - data hold: clear release after 8th fall of received data byte
// - scl held only once sampled low after release bit clears or update flag sets
// - held scl stays low until release set and line otherwise free
// - setting release bit frees scl unless an update is pending outside the ack sequence
`timescale 1ns/1ps
module icss_slave
    import icss_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      scl_oe,
    output logic      sda_out,
    output logic      sda_oe,
    input  icss_ctrl_s ctrl,
    output icss_stat_s stat
);
    icss_bus_s   bus;
    icss_state_e state, next_state;
    logic [7:0]  shreg, next_shreg;
    logic [3:0]  bitcnt, next_bitcnt;
    logic        release_bit, next_release_bit;
    logic        irq, next_irq;
    logic        ack_time, next_ack_time;
    logic        ack_rx, next_ack_rx;
    logic        bfull, next_bfull;
    logic        ua, next_ua;
    logic        rdir, next_rdir;
    logic        dna, next_dna;
    logic [7:0]  rxbuf, next_rxbuf;
    logic [7:0]  txbuf, next_txbuf;
    logic [7:0]  addr, next_addr;
    logic        held, next_held;
    logic        ack_bit, next_ack_bit;
    logic        sda_low, next_sda_low;
    logic        hold_ack, next_hold_ack;
    logic        was_high, next_was_high;
    logic        stretch_req;

    icss_pin_sync u_sync (
        .clk    (clk),
        .reset  (reset),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .bus    (bus)
    );

    function automatic logic addr7_match(input logic [7:0] b,
                                         input logic [7:0] a);
        return b[7:1] == a[7:1];
    endfunction

    function automatic logic high10_match(input logic [7:0] b,
                                          input logic [7:0] a);
        return b[7:3] == TENBIT_HIGH_MARK && b[2:1] == a[2:1];
    endfunction

    // stretch while release cleared or update pending
    // update stretch waits until the acknowledge sequence is over
    assign stretch_req = ~release_bit | (ua & (state != ST_ACK_OUT));

    always_comb begin
        next_state       = state;
        next_shreg       = shreg;
        next_bitcnt      = bitcnt;
        next_release_bit = release_bit;
        next_irq         = irq;
        next_ack_time    = ack_time;
        next_ack_rx      = ack_rx;
        next_bfull       = bfull;
        next_ua          = ua;
        next_rdir        = rdir;
        next_dna         = dna;
        next_rxbuf       = rxbuf;
        next_txbuf       = txbuf;
        next_addr        = addr;
        next_held        = held;
        next_ack_bit     = ack_bit;
        next_sda_low     = sda_low;
        next_hold_ack    = hold_ack;
        next_was_high    = was_high;

        if (ctrl.irq_clr) next_irq = 1'b0;
        if (ctrl.buf_read) next_bfull = 1'b0;
        if (ctrl.release_clr) next_release_bit = 1'b0;
        if (ctrl.release_set) next_release_bit = 1'b1;
        if (ctrl.addr_write) begin
            next_addr = ctrl.addr_wdata;
            next_ua   = 1'b0;
        end
        if (ctrl.buf_write && state != ST_RX_DATA) begin
            next_txbuf = ctrl.buf_wdata;
            next_bfull = 1'b1;
        end

        // hold only after the line is seen low
        if (!stretch_req) next_held = 1'b0;
        else if (!bus.scl) next_held = 1'b1;

        // held acknowledge resolves once release is set
        if (hold_ack && release_bit) begin
            next_hold_ack = 1'b0;
            next_sda_low  = ~ctrl.ack_value_sel;
            next_ack_bit  = ~ctrl.ack_value_sel;
        end

        case (state)
            ST_IDLE: ;
            ST_ADDR, ST_ADDR_LOW, ST_RX_DATA: begin
                if (bus.scl_rise) begin
                    next_shreg  = {shreg[6:0], bus.sda};
                    next_bitcnt = bitcnt + 4'h1;
                end
                if (bus.scl_fall && bitcnt == 4'(BITS_PER_BYTE)) begin
                    next_bitcnt  = 4'h0;
                    next_sda_low = 1'b1;
                    next_ack_bit = 1'b1;
                    next_ack_time = 1'b1;
                    next_state   = ST_ACK_OUT;
                    if (state == ST_ADDR) begin
                        if (ctrl.ten_bit_en
                            && high10_match(shreg, addr)) begin
                            next_rdir  = shreg[0];
                            next_dna   = 1'b0;
                            next_rxbuf = shreg;
                            next_bfull = 1'b1;
                            next_ua    = ~shreg[0];
                            next_was_high = ~shreg[0];
                        end else if (!ctrl.ten_bit_en
                                     && addr7_match(shreg, addr)) begin
                            next_rdir  = shreg[0];
                            next_dna   = 1'b0;
                            next_rxbuf = shreg;
                            next_bfull = 1'b1;
                        end else begin
                            next_sda_low  = 1'b0;
                            next_ack_bit  = 1'b0;
                            next_ack_time = 1'b0;
                            next_state    = ST_IGNORE;
                        end
                        if (next_state == ST_ACK_OUT
                            && ctrl.addr_hold_en) begin
                            next_release_bit = 1'b0;
                            next_irq         = 1'b1;
                            next_sda_low     = 1'b0;
                            next_hold_ack    = 1'b1;
                        end
                    end else if (state == ST_ADDR_LOW) begin
                        next_ua  = 1'b1;
                        if (shreg == addr) begin
                            next_rxbuf = shreg;
                            next_bfull = 1'b1;
                            if (ctrl.addr_hold_en) begin
                                next_irq         = 1'b1;
                                next_release_bit = 1'b0;
                                next_sda_low     = 1'b0;
                                next_hold_ack    = 1'b1;
                            end
                        end else begin
                            next_irq      = 1'b1;
                            next_sda_low  = 1'b0;
                            next_ack_bit  = 1'b0;
                            next_state    = ST_IGNORE;
                        end
                    end else begin
                        next_rxbuf = shreg;
                        next_bfull = 1'b1;
                        next_dna   = 1'b1;
                        if (ctrl.data_hold_en) begin
                            next_release_bit = 1'b0;
                            next_irq         = 1'b1;
                            next_sda_low     = 1'b0;
                            next_hold_ack    = 1'b1;
                        end
                    end
                end
            end
            ST_ACK_OUT: begin
                if (bus.scl_fall && !hold_ack) begin
                    next_sda_low  = 1'b0;
                    next_ack_time = 1'b0;
                    if (!ack_bit) begin
                        next_state = ST_IGNORE;
                    end else begin
                        next_irq = 1'b1;
                        if (was_high && !rdir) begin
                            next_state    = ST_ADDR_LOW;
                            next_was_high = 1'b0;
                        end else if (rdir) begin
                            next_release_bit = 1'b0;
                            next_state       = ST_TX_DATA;
                            next_shreg       = txbuf;
                        end else begin
                            if (ctrl.stretch_en)
                                next_release_bit = 1'b0;
                            next_state = ST_RX_DATA;
                        end
                    end
                end
            end
            ST_TX_DATA: begin
                // load buffered byte while scl held
                if (held && bfull) begin
                    next_shreg = txbuf;
                    next_sda_low = ~txbuf[7];
                end
                if (bus.scl_fall && release_bit) begin
                    next_bitcnt = bitcnt + 4'h1;
                    next_bfull  = 1'b0;
                    if (bitcnt == 4'(BITS_PER_BYTE - 1)) begin
                        next_sda_low = 1'b0;
                        next_bitcnt  = 4'h0;
                        next_state   = ST_ACK_IN;
                    end else begin
                        next_shreg   = {shreg[6:0], 1'b0};
                        next_sda_low = ~shreg[6];
                    end
                end
            end
            ST_ACK_IN: begin
                if (bus.scl_rise)
                    next_ack_rx = bus.sda;
                if (bus.scl_fall) begin
                    next_irq = 1'b1;
                    if (ack_rx) begin
                        next_state = ST_IGNORE;
                    end else begin
                        next_release_bit = 1'b0;
                        next_shreg   = txbuf;
                        next_state   = ST_TX_DATA;
                    end
                end
            end
            ST_IGNORE: ;
            default: next_state = ST_IDLE;
        endcase

        if (bus.start) begin
            next_state    = ST_ADDR;
            next_was_high = 1'b0;
            next_bitcnt   = 4'h0;
            next_sda_low  = 1'b0;
            next_hold_ack = 1'b0;
        end else if (bus.stop) begin
            next_state    = ST_IDLE;
            next_sda_low  = 1'b0;
            next_hold_ack = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state       <= ST_IDLE;
            shreg       <= BUF_RESET;
            bitcnt      <= 4'h0;
            release_bit <= 1'b1;
            irq         <= 1'b0;
            ack_time    <= 1'b0;
            ack_rx      <= 1'b0;
            bfull       <= 1'b0;
            ua          <= 1'b0;
            rdir        <= 1'b0;
            dna         <= 1'b0;
            rxbuf       <= BUF_RESET;
            txbuf       <= BUF_RESET;
            addr        <= ADDR_RESET;
            held        <= 1'b0;
            ack_bit     <= 1'b0;
            sda_low     <= 1'b0;
            hold_ack    <= 1'b0;
            was_high    <= 1'b0;
        end else begin
            state       <= next_state;
            shreg       <= next_shreg;
            bitcnt      <= next_bitcnt;
            release_bit <= next_release_bit;
            irq         <= next_irq;
            ack_time    <= next_ack_time;
            ack_rx      <= next_ack_rx;
            bfull       <= next_bfull;
            ua          <= next_ua;
            rdir        <= next_rdir;
            dna         <= next_dna;
            rxbuf       <= next_rxbuf;
            txbuf       <= next_txbuf;
            addr        <= next_addr;
            held        <= next_held;
            ack_bit     <= next_ack_bit;
            sda_low     <= next_sda_low;
            hold_ack    <= next_hold_ack;
            was_high    <= next_was_high;
        end
    end

    // open drain drive: out fixed low, enable pulls
    assign scl_out = 1'b0;
    assign scl_oe  = held;
    assign sda_out = 1'b0;
    assign sda_oe  = sda_low;

    always_comb begin
        stat.clock_release_bit   = release_bit;
        stat.port_irq_flag       = irq;
        stat.ack_time_flag       = ack_time;
        stat.ack_received_status = ack_rx;
        stat.buffer_full_flag    = bfull;
        stat.update_addr_flag    = ua;
        stat.read_dir            = rdir;
        stat.data_not_addr       = dna;
        stat.shift_buffer        = rxbuf;
        stat.slave_addr_reg      = addr;
    end
endmodule

// ### verilog/icss_pkg.sv
// package for the i2c slave with clock stretch and 10-bit addressing
// assumes a single system clock; bus pins are open drain via enables
package icss_pkg;
    localparam int  SYNC_STAGES    = 2;
    localparam int  BITS_PER_BYTE  = 8;
    localparam logic [4:0] TENBIT_HIGH_MARK = 5'h1E;
    localparam logic [7:0] ADDR_RESET   = 8'h00;
    localparam logic [7:0] BUF_RESET    = 8'h00;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_LOW,
        ST_RX_DATA,
        ST_TX_DATA,
        ST_ACK_OUT,
        ST_ACK_IN,
        ST_IGNORE
    } icss_state_e;

    // sampled bus view
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } icss_bus_s;

    // software control strobes and levels
    typedef struct packed {
        logic       addr_hold_en;
        logic       data_hold_en;
        logic       stretch_en;
        logic       ten_bit_en;
        logic       ack_value_sel;
        logic       release_set;
        logic       release_clr;
        logic       irq_clr;
        logic       buf_write;
        logic       buf_read;
        logic       addr_write;
        logic [7:0] addr_wdata;
        logic [7:0] buf_wdata;
    } icss_ctrl_s;

    // status seen by software
    typedef struct packed {
        logic       clock_release_bit;
        logic       port_irq_flag;
        logic       ack_time_flag;
        logic       ack_received_status;
        logic       buffer_full_flag;
        logic       update_addr_flag;
        logic       read_dir;
        logic       data_not_addr;
        logic [7:0] shift_buffer;
        logic [7:0] slave_addr_reg;
    } icss_stat_s;
endpackage

// ### verilog/icss_pin_sync.sv
// two-flop synchroniser and edge finder for scl and sda
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module icss_pin_sync
    import icss_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset,
    input  wire logic      scl_in,
    input  wire logic      sda_in,
    output icss_bus_s      bus
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_d;
    logic       sda_d;
    logic [1:0] next_scl_meta;
    logic [1:0] next_sda_meta;

    always_comb begin
        next_scl_meta = {scl_meta[0], scl_in};
        next_sda_meta = {sda_meta[0], sda_in};
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_meta <= next_scl_meta;
            sda_meta <= next_sda_meta;
            scl_d    <= scl_meta[1];
            sda_d    <= sda_meta[1];
        end
    end

    always_comb begin
        bus.scl      = scl_meta[1];
        bus.sda      = sda_meta[1];
        bus.scl_rise = scl_meta[1] & ~scl_d;
        bus.scl_fall = ~scl_meta[1] & scl_d;
        bus.start    = scl_meta[1] & scl_d & sda_d & ~sda_meta[1];
        bus.stop     = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];
    end
endmodule

// ### tb/icss_slave_sva.sv
// checker for icss_slave: clock stretch, release and address handshake
// assumes it is bound onto icss_slave and sees only its ports
`timescale 1ns/1ps
module icss_slave_sva
    import icss_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input icss_ctrl_s ctrl,
    input icss_stat_s stat
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_hold_after_low; $rose(scl_oe) |-> !$past(scl_in); endproperty
    a_hold_after_low: assert property (p_hold_after_low)
        else $error("scl pulled low while line was high");
    property p_free_needs_rel; $fell(scl_oe) |-> stat.clock_release_bit;
    endproperty
    a_free_needs_rel: assert property (p_free_needs_rel)
        else $error("scl freed with release bit clear");
    property p_release_frees;
        ctrl.release_set && scl_oe && !stat.update_addr_flag
            |-> ##[1:6] !scl_oe;
    endproperty
    a_release_frees: assert property (p_release_frees)
        else $error("scl not freed after release set");
    property p_addr_write_frees;
        ctrl.addr_write && stat.update_addr_flag && stat.clock_release_bit
            && scl_oe |-> ##[1:6] !scl_oe;
    endproperty
    a_addr_write_frees: assert property (p_addr_write_frees)
        else $error("scl not freed after address write");
    property p_ua_keeps_rel;
        $rose(stat.update_addr_flag) && !ctrl.addr_hold_en
            |-> $stable(stat.clock_release_bit);
    endproperty
    a_ua_keeps_rel: assert property (p_ua_keeps_rel)
        else $error("update flag changed the release bit");
    property p_buf_full;
        ctrl.buf_write && stat.read_dir |=> stat.buffer_full_flag;
    endproperty
    a_buf_full: assert property (p_buf_full)
        else $error("buffer write did not set full flag");
    property p_nack_no_hold;
        $rose(stat.ack_received_status) |-> (!scl_oe) [*8];
    endproperty
    a_nack_no_hold: assert property (p_nack_no_hold)
        else $error("scl held after master nack");
    property p_ua_tenbit;
        $rose(stat.update_addr_flag) |-> ctrl.ten_bit_en;
    endproperty
    a_ua_tenbit: assert property (p_ua_tenbit)
        else $error("update flag set outside 10-bit mode");

    c_ua: cover property ($rose(stat.update_addr_flag));
    c_hold: cover property ($fell(stat.clock_release_bit));
    c_nack: cover property ($rose(stat.ack_received_status));
    c_full: cover property ($rose(stat.buffer_full_flag));
endmodule

bind icss_slave icss_slave_sva u_sva (
    .clk     (clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .scl_out (scl_out),
    .scl_oe  (scl_oe),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .ctrl    (ctrl),
    .stat    (stat)
);

// ### tb/icss_master_model.sv
// behavioural i2c bus master, bit timing in ns, 200 ns scl period
// assumes pull-ups on both lines; oe high pulls a line low
`timescale 1ns/1ps
module icss_master_model (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_oe,
    output logic      sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // wait out a slave stretch, bounded
    task automatic wait_high();
        for (int i = 0; i < 4000 && scl_line !== 1'b1; i++) begin
            #25;
        end
    endtask
    // level read late in the high phase, after slave output settles
    task automatic bit_xfer(input logic b, output logic r);
        #50 sda_oe = !b;
        #50 scl_oe = 1'b0;
        wait_high();
        #90 r = sda_line;
        #10 scl_oe = 1'b1;
    endtask
    task automatic start();
        #100 sda_oe = 1'b1;
        #100 scl_oe = 1'b1;
    endtask
    task automatic stop();
        #50 sda_oe = 1'b1;
        #50 scl_oe = 1'b0;
        wait_high();
        #100 sda_oe = 1'b0;
        #200;
    endtask
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(v[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask
    task automatic byte_in(output logic [7:0] v, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            v[i] = r;
        end
        bit_xfer(ack, r);
    endtask
endmodule

// ### tb/test_icss_slave.sv
// bench for icss_slave: software strobes against a model bus master
// assumes tb/icss_master_model.sv and the bound checker
`timescale 1ns/1ps
module test_icss_slave
    import icss_pkg::*;
;
    localparam int K_REL = 0, K_CLR = 1, K_BUF = 2, K_ADR = 3, K_RD = 4;
    logic       clk;
    logic       reset;
    logic       m_scl_oe;
    logic       m_sda_oe;
    logic       scl_oe;
    logic       sda_oe;
    icss_ctrl_s ctrl;
    icss_stat_s stat;
    int         err_count;
    int         checks;
    wire logic  scl_line = !(m_scl_oe || scl_oe);
    wire logic  sda_line = !(m_sda_oe || sda_oe);

    icss_slave uut (.clk(clk), .reset(reset), .scl_in(scl_line),
        .sda_in(sda_line), .scl_out(), .scl_oe(scl_oe), .sda_out(),
        .sda_oe(sda_oe), .ctrl(ctrl), .stat(stat));
    icss_master_model mst (.scl_line(scl_line), .sda_line(sda_line),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    initial clk = 1'b0;
    always #12.5 clk = !clk;

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // one-cycle software strobe
    task automatic pulse(input int k, input logic [7:0] v);
        @(posedge clk) #2;
        case (k)
            K_REL: ctrl.release_set = 1'b1;
            K_CLR: ctrl.irq_clr = 1'b1;
            K_BUF: {ctrl.buf_write, ctrl.buf_wdata} = {1'b1, v};
            K_ADR: {ctrl.addr_write, ctrl.addr_wdata} = {1'b1, v};
            default: ctrl.buf_read = 1'b1;
        endcase
        @(posedge clk) #2;
        {ctrl.release_set, ctrl.irq_clr, ctrl.buf_write} = 3'h0;
        {ctrl.addr_write, ctrl.buf_read} = 2'h0;
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 4000 && stat.port_irq_flag !== 1'b1; i++) begin
            cyc(1);
        end
        chk("irq", 8'(stat.port_irq_flag), 8'h01);
    endtask
    task automatic clr_rd();
        pulse(K_CLR, 8'h00);
        pulse(K_RD, 8'h00);
    endtask

    initial begin
        #400000;
        err_count++;
        end_of_test();
    end

    initial begin
        logic [7:0] d;
        logic       a;
        err_count = 0;
        checks = 0;
        ctrl = '0;
        reset = 1'b1;
        repeat (12) @(posedge clk);
        #2 reset = 1'b0;
        cyc(4);
        chk("rst", {4'h0, stat.clock_release_bit, stat.port_irq_flag,
            scl_oe, sda_oe}, 8'h08);
        chk("rst addr", stat.slave_addr_reg, ADDR_RESET);
        // 7-bit read with address hold
        ctrl.addr_hold_en = 1'b1;
        pulse(K_ADR, 8'hA4);
        fork
            begin
                mst.start();
                mst.byte_out(8'hA5, a);
                chk("addr ack", 8'(a), 8'h00);
                mst.byte_in(d, 1'b0);
                chk("rd 1", d, 8'hC3);
                mst.byte_in(d, 1'b1);
                chk("rd 2", d, 8'h3C);
                mst.stop();
            end
            begin
                wait_irq();
                chk("rel a", 8'(stat.clock_release_bit), 8'h00);
                cyc(6);
                d = {5'h00, stat.ack_time_flag, scl_oe, stat.read_dir};
                chk("held", d, 8'h07);
                clr_rd();
                pulse(K_REL, 8'h00);
                wait_irq();
                cyc(2);
                chk("rel rd", 8'(stat.clock_release_bit), 8'h00);
                pulse(K_CLR, 8'h00);
                pulse(K_BUF, 8'hC3);
                chk("bf", 8'(stat.buffer_full_flag), 8'h01);
                pulse(K_REL, 8'h00);
                wait_irq();
                cyc(2);
                d = {6'h00, stat.ack_received_status, stat.clock_release_bit};
                chk("ack rx", d, 8'h00);
                pulse(K_CLR, 8'h00);
                pulse(K_BUF, 8'h3C);
                pulse(K_REL, 8'h00);
                wait_irq();
                cyc(2);
                chk("nack rx", 8'(stat.ack_received_status), 8'h01);
                cyc(8);
                chk("no hold", 8'(scl_oe), 8'h00);
            end
        join
        clr_rd();
        ctrl.addr_hold_en = 1'b0;
        // 7-bit write with data hold, software nack
        ctrl.data_hold_en = 1'b1;
        fork
            begin
                mst.start();
                mst.byte_out(8'hA4, a);
                chk("wr ack", 8'(a), 8'h00);
                mst.byte_out(8'h96, a);
                chk("sw nack", 8'(a), 8'h01);
                mst.stop();
            end
            begin
                wait_irq();
                clr_rd();
                wait_irq();
                d = {6'h00, stat.data_not_addr, stat.clock_release_bit};
                chk("rel d", d, 8'h02);
                ctrl.ack_value_sel = 1'b1;
                pulse(K_CLR, 8'h00);
                pulse(K_REL, 8'h00);
            end
        join
        chk("rx byte", stat.shift_buffer, 8'h96);
        ctrl.data_hold_en = 1'b0;
        ctrl.ack_value_sel = 1'b0;
        clr_rd();
        // 10-bit write: match, then low byte mismatch
        ctrl.ten_bit_en = 1'b1;
        pulse(K_ADR, 8'hF2);
        for (int m = 0; m < 2; m++) begin
            fork
                begin
                    mst.start();
                    mst.byte_out(8'hF2, a);
                    chk("hi ack", 8'(a), 8'h00);
                    mst.byte_out(m ? 8'h35 : 8'h34, a);
                    chk("lo ack", 8'(a), 8'(m));
                    if (m == 0) mst.byte_out(8'h55, a);
                    if (m == 0) chk("d ack", 8'(a), 8'h00);
                    mst.stop();
                end
                begin
                    wait_irq();
                    cyc(6);
                    d = {5'h00, stat.update_addr_flag, scl_oe,
                        stat.clock_release_bit};
                    chk("ua hold", d, 8'h07);
                    clr_rd();
                    pulse(K_ADR, 8'h34);
                    wait_irq();
                    cyc(6);
                    d = {4'h0, stat.update_addr_flag, stat.buffer_full_flag,
                        stat.clock_release_bit, scl_oe};
                    chk("ua lo", d, m ? 8'h0B : 8'h0F);
                    clr_rd();
                    ctrl.stretch_en = (m == 0);
                    pulse(K_ADR, 8'hF2);
                    if (m == 0) begin
                        wait_irq();
                        cyc(6);
                        d = {6'h00, scl_oe, stat.clock_release_bit};
                        chk("sen", d, 8'h02);
                        clr_rd();
                        pulse(K_REL, 8'h00);
                    end
                end
            join
            ctrl.stretch_en = 1'b0;
            clr_rd();
        end
        end_of_test();
    end
endmodule
